/* rtl/lfrc_pkg.sv */
// Package: register map, field layout and timing of the receiver control block
package lfrc_pkg;
  // Register indices (byte address = 4 * index)
  localparam logic [7:0] LFRC_CTRL4_IDX = 8'h23;
  localparam logic [7:0] LFRC_STAT_IDX = 8'h24;
  localparam logic [7:0] LFRC_MASK_IDX = 8'h25;
  localparam int LFRC_ADDR_W = 10;
  // Control register fields
  localparam int LFRC_DR_IE_BIT = 7;
  localparam int LFRC_ER_IE_BIT = 6;
  localparam int LFRC_CD_IE_BIT = 5;
  localparam int LFRC_ID_IE_BIT = 4;
  localparam int LFRC_DEC_EN_BIT = 3;
  localparam int LFRC_VAL_EN_BIT = 2;
  localparam int LFRC_TMO_LSB = 0;
  localparam logic [7:0] LFRC_CTRL4_RST = 8'h0f;
  // Status register fields
  localparam int LFRC_DR_F_BIT = 7;
  localparam int LFRC_ER_F_BIT = 6;
  localparam int LFRC_CD_F_BIT = 5;
  localparam int LFRC_ID_F_BIT = 4;
  localparam int LFRC_TMO_F_BIT = 3;
  localparam int LFRC_ACK_BIT = 0;
  localparam logic [7:0] LFRC_STAT_RST = 8'h00;
  localparam logic [7:0] LFRC_STAT_MASK = 8'hf8;
  localparam logic [7:0] LFRC_ACK_CLR = 8'he0;
  localparam logic [7:0] LFRC_MASK_RST = 8'h00;
  // Search timeout, in ms, and oscillator rate in kHz
  localparam int LFRC_TMO1_MS = 8;
  localparam int LFRC_TMO2_MS = 24;
  localparam int LFRC_TMO3_MS = 48;
  localparam int LFRC_RECEIVER_LOW_FREQ_OSCILLATOR_KHZ = 125;
  localparam int LFRC_CNT_W = 16;
  localparam int LFRC_TMO1_TICKS = LFRC_TMO1_MS * LFRC_RECEIVER_LOW_FREQ_OSCILLATOR_KHZ;
  localparam int LFRC_TMO2_TICKS = LFRC_TMO2_MS * LFRC_RECEIVER_LOW_FREQ_OSCILLATOR_KHZ;
  localparam int LFRC_TMO3_TICKS = LFRC_TMO3_MS * LFRC_RECEIVER_LOW_FREQ_OSCILLATOR_KHZ;
  // Timeout selection codes
  typedef enum logic [1:0] {
    LFRC_TMO_NONE = 2'b00,
    LFRC_TMO_SHORT = 2'b01,
    LFRC_TMO_MID = 2'b10,
    LFRC_TMO_LONG = 2'b11
  } lfrc_tmo_t;
endpackage : lfrc_pkg

/* rtl/lfrc_sync_timer.sv */
// SYNC search timer counted in receiver oscillator ticks
`timescale 1ns/1ps
module lfrc_sync_timer #(
  parameter int T1 = lfrc_pkg::LFRC_TMO1_TICKS,
  parameter int T2 = lfrc_pkg::LFRC_TMO2_TICKS,
  parameter int T3 = lfrc_pkg::LFRC_TMO3_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic tick_i,
  input wire logic search_i,
  input wire logic sync_found_i,
  input wire lfrc_pkg::lfrc_tmo_t sel_i,
  output logic expire_o
);
  import lfrc_pkg::*;

  typedef enum logic [0:0] {
    LFRC_ST_IDLE = 1'b0,
    LFRC_ST_SEARCH = 1'b1
  } lfrc_tst_t;

  lfrc_tst_t state_r;
  logic [LFRC_CNT_W-1:0] cnt_r;
  logic [LFRC_CNT_W-1:0] limit;
  logic search_d_r;

  // Tick limit for the selected interval
  always_comb
  begin
    case (sel_i)
      LFRC_TMO_SHORT: limit = LFRC_CNT_W'(T1);
      LFRC_TMO_MID: limit = LFRC_CNT_W'(T2);
      LFRC_TMO_LONG: limit = LFRC_CNT_W'(T3);
      default: limit = '0;
    endcase
  end

  // Search start edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_i)
      search_d_r <= 1'b0;
    else
      search_d_r <= search_i;
  end

  // Search state, tick count and expiry pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_i)
    begin
      state_r <= LFRC_ST_IDLE;
      cnt_r <= '0;
      expire_o <= 1'b0;
    end
    else
    begin
      expire_o <= 1'b0;
      case (state_r)
        LFRC_ST_IDLE:
        begin
          cnt_r <= '0;
          if (search_i && !search_d_r && sel_i != LFRC_TMO_NONE)
            state_r <= LFRC_ST_SEARCH;
        end
        LFRC_ST_SEARCH:
        begin
          if (!search_i || sync_found_i || sel_i == LFRC_TMO_NONE)
            state_r <= LFRC_ST_IDLE;
          else if (tick_i)
          begin
            if (cnt_r + LFRC_CNT_W'(1) >= limit)
            begin
              expire_o <= 1'b1;
              state_r <= LFRC_ST_IDLE;
            end
            cnt_r <= cnt_r + LFRC_CNT_W'(1);
          end
        end
        default: state_r <= LFRC_ST_IDLE;
      endcase
    end
  end
endmodule : lfrc_sync_timer

/* rtl/lfrc_ctrl.sv */
// Receiver control register, flags, interrupt and SYNC timeout over Wishbone
//
// Operation
// - Data-ready flag requests interrupt only while data-full enable bit 7 is set.
// - Receive-error flag requests interrupt only while error enable bit 6 is set.
// - Error flag covers bad Manchester bit, sampling error and ID mismatch.
// - Carrier-detect flag requests interrupt only while enable bit 5 is set.
// - ID-match flag, set on ID match, interrupts only while enable bit 4 set.
// - Decoder enable bit 3 clear skips checking and sets no data/error/ID flags.
// - Carrier validation runs only while validation enable bit 2 is set.
// - Timeout field picks search time: none, 8 ms, 24 ms, 48 ms.
// - Receiver is switched off when SYNC search time expires in data mode.
// - Search interval is counted in receiver oscillator cycles.
// - Power-on and soft reset load 0x0f; other resets keep the register.
// - Writing one to acknowledge bit clears the receive-error flag; the code also clears the data-ready and carrier-detect flags.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module lfrc_ctrl #(
  parameter int TMO1_TICKS = lfrc_pkg::LFRC_TMO1_TICKS,
  parameter int TMO2_TICKS = lfrc_pkg::LFRC_TMO2_TICKS,
  parameter int TMO3_TICKS = lfrc_pkg::LFRC_TMO3_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lfrc_pkg::LFRC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic receiver_low_freq_oscillator_clk_i,
  input wire logic data_mode_i,
  input wire logic byte_done_i,
  input wire logic manchester_err_i,
  input wire logic sampling_err_i,
  input wire logic id_done_i,
  input wire logic id_ok_i,
  input wire logic carrier_valid_i,
  input wire logic sync_found_i,
  output logic decoder_enable_o,
  output logic carrier_validation_enable_o,
  output logic receiver_off_o,
  output logic irq_o
);
  import lfrc_pkg::*;

  logic [7:0] ctrl_r;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] mask_r;
  logic [7:0] set_ev;
  logic [7:0] clr_ev;
  logic [7:0] irq_en;
  logic [2:0] receiver_low_freq_oscillator_sync_r;
  logic receiver_low_freq_oscillator_tick;
  logic req;
  logic wr_lo;
  logic [7:0] idx;
  logic expire;
  logic dec_en;
  logic val_en;

  // Word index from byte address
  function automatic logic [7:0] word_idx(input logic [LFRC_ADDR_W-1:0] a);
    word_idx = a[LFRC_ADDR_W-1:2];
  endfunction : word_idx

  // Bus decode and control fields
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = word_idx(wb_adr_i);
  assign wr_lo = req && wb_we_i && wb_sel_i[0];
  assign dec_en = ctrl_r[LFRC_DEC_EN_BIT];
  assign val_en = ctrl_r[LFRC_VAL_EN_BIT];

  // Oscillator clock synchroniser and rising-edge tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      receiver_low_freq_oscillator_sync_r <= 3'h0;
    else
      receiver_low_freq_oscillator_sync_r <= {receiver_low_freq_oscillator_sync_r[1:0], receiver_low_freq_oscillator_clk_i};
  end
  assign receiver_low_freq_oscillator_tick = receiver_low_freq_oscillator_sync_r[1] && !receiver_low_freq_oscillator_sync_r[2];

  // Control register: preset on power-on or soft reset only
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_i)
      ctrl_r <= LFRC_CTRL4_RST;
    else if (wr_lo && idx == LFRC_CTRL4_IDX)
      ctrl_r <= wb_dat_i[7:0];
  end

  // Mask register for the timeout event
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_i)
      mask_r <= LFRC_MASK_RST;
    else if (wr_lo && idx == LFRC_MASK_IDX)
      mask_r <= wb_dat_i[7:0] & LFRC_STAT_MASK;
  end

  // Flag set events; decoder off blocks data, error and ID flags
  always_comb
  begin
    set_ev = 8'h00;
    set_ev[LFRC_DR_F_BIT] = dec_en && byte_done_i;
    set_ev[LFRC_ER_F_BIT] = dec_en && (manchester_err_i || sampling_err_i
                                        || (id_done_i && !id_ok_i));
    set_ev[LFRC_ID_F_BIT] = dec_en && id_done_i && id_ok_i;
    set_ev[LFRC_CD_F_BIT] = val_en && carrier_valid_i;
    set_ev[LFRC_TMO_F_BIT] = expire;
  end

  // Flag clears: write one per bit, or acknowledge bit
  always_comb
  begin
    clr_ev = 8'h00;
    if (wr_lo && idx == LFRC_STAT_IDX)
    begin
      clr_ev = wb_dat_i[7:0] & LFRC_STAT_MASK;
      if (wb_dat_i[LFRC_ACK_BIT])
        clr_ev = clr_ev | LFRC_ACK_CLR;
    end
  end

  // Sticky flags, a set beats a clear in the same cycle
  assign stat_nxt = (stat_r & ~clr_ev) | set_ev;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_i)
      stat_r <= LFRC_STAT_RST;
    else
      stat_r <= stat_nxt & LFRC_STAT_MASK;
  end

  // Per-flag gates: control enables for flags, mask for timeout
  always_comb
  begin
    irq_en = mask_r;
    irq_en[LFRC_DR_F_BIT] = ctrl_r[LFRC_DR_IE_BIT];
    irq_en[LFRC_ER_F_BIT] = ctrl_r[LFRC_ER_IE_BIT];
    irq_en[LFRC_CD_F_BIT] = ctrl_r[LFRC_CD_IE_BIT];
    irq_en[LFRC_ID_F_BIT] = ctrl_r[LFRC_ID_IE_BIT];
  end

  // Interrupt level
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(stat_r & irq_en);
  end

  // Wishbone acknowledge, one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // Read data, unmapped words read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i)
    begin
      case (idx)
        LFRC_CTRL4_IDX: wb_dat_o <= {24'h00_0000, ctrl_r};
        LFRC_STAT_IDX: wb_dat_o <= {24'h00_0000, stat_r};
        LFRC_MASK_IDX: wb_dat_o <= {24'h00_0000, mask_r};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // SYNC search timer
  lfrc_sync_timer #(
    .T1(TMO1_TICKS),
    .T2(TMO2_TICKS),
    .T3(TMO3_TICKS)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .soft_rst_i(soft_rst_i),
    .tick_i(receiver_low_freq_oscillator_tick),
    .search_i(data_mode_i && dec_en),
    .sync_found_i(sync_found_i),
    .sel_i(lfrc_tmo_t'(ctrl_r[LFRC_TMO_LSB +: 2])),
    .expire_o(expire)
  );

  // Enables and receiver switch-off, all from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_i)
    begin
      decoder_enable_o <= 1'b1;
      carrier_validation_enable_o <= 1'b1;
      receiver_off_o <= 1'b0;
    end
    else
    begin
      decoder_enable_o <= dec_en;
      carrier_validation_enable_o <= val_en;
      receiver_off_o <= expire;
    end
  end

  // Bus request and control write sequences
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctrl_wr;
    s_bus_req ##0 (wb_we_i && wb_sel_i[0] && word_idx(wb_adr_i) == LFRC_CTRL4_IDX && !soft_rst_i);
  endsequence

  a_ctrl_reset_val: assert property (@(posedge clk_i)
    (rst_i || soft_rst_i) |=> ctrl_r == 8'h0f)
    else $error("control register not preset to 0f");
  a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctrl_wr |=> ctrl_r == $past(wb_dat_i[7:0]))
    else $error("control write not stored");
  a_dr_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (stat_r[7] && ctrl_r[7]) |=> irq_o)
    else $error("data ready interrupt missing");
  a_er_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (stat_r[6] && ctrl_r[6]) |=> irq_o)
    else $error("error interrupt missing");
  a_cd_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (stat_r[5] && ctrl_r[5]) |=> irq_o)
    else $error("carrier interrupt missing");
  a_id_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (stat_r[4] && ctrl_r[4]) |=> irq_o)
    else $error("id interrupt missing");
  a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    ((stat_r & {ctrl_r[7:4], mask_r[3:0]}) == 8'h00) |=> !irq_o)
    else $error("interrupt without enabled flag");
  a_dec_off_flags: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (!ctrl_r[3] && !stat_r[7] && !stat_r[6] && !stat_r[4]) |=> (!stat_r[7] && !stat_r[6] && !stat_r[4]))
    else $error("flag set while decoder off");
  a_err_cases: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (ctrl_r[3] && (manchester_err_i || sampling_err_i || (id_done_i && !id_ok_i))) |=> stat_r[6])
    else $error("receive error not flagged");
  a_val_off: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (!ctrl_r[2] && !stat_r[5]) |=> !stat_r[5])
    else $error("carrier flag while validation off");
  a_ack_clears: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (s_bus_req ##0 (wb_we_i && wb_sel_i[0] && wb_dat_i[0] && idx == LFRC_STAT_IDX && !set_ev[6])) |=> !stat_r[6])
    else $error("acknowledge did not clear error flag");
  a_off_follows: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    expire |=> receiver_off_o ##1 !receiver_off_o)
    else $error("receiver off pulse wrong");
  a_no_tmo_none: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (ctrl_r[1:0] == 2'b00) |=> !expire)
    else $error("timeout with no-timeout selection");

  // Bus handshake and read path
  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_req |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_rdata_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> (wb_dat_o[31:8] == 24'h00_0000))
    else $error("upper read data not zero");
  a_ctrl_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_bus_req ##0 (!wb_we_i && idx == LFRC_CTRL4_IDX)) |=> (wb_dat_o[7:0] == $past(ctrl_r)))
    else $error("control read data wrong");

  // Register retention, flag setting and enable outputs
  a_ctrl_keep: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    !(wr_lo && idx == LFRC_CTRL4_IDX) |=> (ctrl_r == $past(ctrl_r)))
    else $error("control register changed without write");
  a_stat_reset: assert property (@(posedge clk_i)
    (rst_i || soft_rst_i) |=> (stat_r == LFRC_STAT_RST))
    else $error("status not cleared by reset");
  a_dr_flag_set: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (ctrl_r[3] && byte_done_i) |=> stat_r[7])
    else $error("data ready flag not set");
  a_id_flag_set: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (ctrl_r[3] && id_done_i && id_ok_i) |=> stat_r[4])
    else $error("id match flag not set");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (stat_r[7] && !clr_ev[7]) |=> stat_r[7])
    else $error("data ready flag dropped without clear");
  a_dec_en_copy: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    1'b1 |=> (decoder_enable_o == $past(dec_en)))
    else $error("decoder enable output wrong");
  a_val_en_copy: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    1'b1 |=> (carrier_validation_enable_o == $past(val_en)))
    else $error("validation enable output wrong");

  // Timer expiry path
  a_expire_on_tick: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    expire |-> $past(receiver_low_freq_oscillator_tick))
    else $error("expiry without oscillator tick");
  a_tmo_flag_set: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    expire |=> stat_r[3])
    else $error("timeout flag not set");
  a_off_needs_expire: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    receiver_off_o |-> $past(expire))
    else $error("receiver off without expiry");
endmodule : lfrc_ctrl

/* tb/lfrc_osc_model.sv */
// Receiver low-frequency oscillator model for the control block bench
`timescale 1ns/1ps
module lfrc_osc_model (
  input wire logic clk_i,
  input wire logic run_i,
  output logic receiver_low_freq_oscillator_o
);
  int cnt;
  // Divide the system clock by twenty, stopped and low while idle
  always @(posedge clk_i)
  begin
    if (!run_i)
    begin
      cnt <= 0;
      receiver_low_freq_oscillator_o <= 1'b0;
    end
    else if (cnt == 9)
    begin
      cnt <= 0;
      receiver_low_freq_oscillator_o <= ~receiver_low_freq_oscillator_o;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : lfrc_osc_model

/* tb/lfrc_ctrl_tb.sv */
// Self-checking bench of the receiver control block
`timescale 1ns/1ps
module lfrc_ctrl_tb;
  import lfrc_pkg::*;
  localparam logic [9:0] A_CTRL = {LFRC_CTRL4_IDX, 2'b00};
  localparam logic [9:0] A_STAT = {LFRC_STAT_IDX, 2'b00};
  localparam logic [9:0] A_MASK = {LFRC_MASK_IDX, 2'b00};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_rst = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, data_mode = 1'b0, run = 1'b0;
  logic sync_found = 1'b0;
  logic [9:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] dat = '0, rd, dat_o;
  logic ack, receiver_low_freq_oscillator, off, dec_en, val_en, irq;
  logic [5:0] ev = '0;
  logic [5:0] ev_tab [4] = '{6'h01, 6'h02, 6'h20, 6'h18};
  logic [15:0] rnd = 16'h18fe;
  int err_count = 0, checks_done = 0, cyc_cnt = 0, ticks = 0, ctrl_m = 'h0f, seen;
  int tmo_q[$] = '{-1, 4, 6, 8, -1};

  lfrc_ctrl #(.TMO1_TICKS(4), .TMO2_TICKS(6), .TMO3_TICKS(8)) lfrc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .soft_rst_i(soft_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .receiver_low_freq_oscillator_clk_i(receiver_low_freq_oscillator), .data_mode_i(data_mode),
    .byte_done_i(ev[0]), .manchester_err_i(ev[1]), .sampling_err_i(ev[2]), .id_done_i(ev[3]),
    .id_ok_i(ev[4]), .carrier_valid_i(ev[5]), .sync_found_i(sync_found), .decoder_enable_o(dec_en),
    .carrier_validation_enable_o(val_en), .receiver_off_o(off), .irq_o(irq));
  lfrc_osc_model lfrc_osc_model_inst (.clk_i(clk_i), .run_i(run), .receiver_low_freq_oscillator_o(receiver_low_freq_oscillator));

  initial forever #2 clk_i = ~clk_i;
  always @(posedge receiver_low_freq_oscillator) ticks++;
  // Hang guard
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h1;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rdchk(input string name, input logic [9:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rdchk

  task automatic pulse(input logic [5:0] e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= '0;
    repeat (3) @(posedge clk_i);
  endtask : pulse

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("ctrl_reset", A_CTRL, 32'h0f);
    rdchk("unmapped", 10'h3fc, 32'h0);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      ctrl_m = rnd[7:0];
      wb(1'b1, A_CTRL, {16'h0, rnd});
      rdchk("ctrl_rw", A_CTRL, ctrl_m);
      check("dec_en", 32'(dec_en), ctrl_m[3]);
      check("val_en", 32'(val_en), ctrl_m[2]);
    end
    $display("test register done");
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, A_CTRL, 32'h0c);
      pulse(ev_tab[i]);
      check("irq_off", 32'(irq), 0);
      rdchk("stat_flag", A_STAT, 32'h80 >> i);
      ctrl_m = 'h0c | ('h80 >> i);
      wb(1'b1, A_CTRL, ctrl_m);
      repeat (3) @(posedge clk_i);
      check("irq_on", 32'(irq), 1);
      wb(1'b1, A_STAT, 32'h80 >> i);
      repeat (3) @(posedge clk_i);
      check("irq_clr", 32'(irq), 0);
    end
    foreach (tmo_q[k])
      if (k < 2)
      begin
        pulse(k == 0 ? 6'h04 : 6'h08);
        rdchk("err_flag", A_STAT, 32'h40);
        wb(1'b1, A_STAT, 32'h01);
        rdchk("err_ack", A_STAT, 32'h0);
      end
    wb(1'b1, A_CTRL, 32'hf0);
    pulse(6'h3f);
    rdchk("dec_off", A_STAT, 32'h0);
    check("irq_dec_off", 32'(irq), 0);
    $display("test flags done");
    wb(1'b1, A_MASK, 32'h08);
    for (int s = 0; s < 5; s++)
    begin
      wb(1'b1, A_CTRL, (s == 4) ? 32'h09 : (32'h08 | s));
      ticks = 0;
      seen = -1;
      data_mode <= 1'b1;
      @(posedge clk_i);
      run <= 1'b1;
      for (int c = 0; c < 400; c++)
      begin
        @(posedge clk_i);
        sync_found <= (s == 4 && c == 40);
        if (off === 1'b1 && seen < 0)
          seen = ticks;
      end
      check("sync_timeout", seen, tmo_q[s]);
      check("tmo_irq", 32'(irq), 32'(tmo_q[s] >= 0));
      run <= 1'b0;
      data_mode <= 1'b0;
      rdchk("tmo_flag", A_STAT, (tmo_q[s] >= 0) ? 32'h08 : 32'h00);
      wb(1'b1, A_STAT, 32'h08);
    end
    $display("test timeout done");
    wb(1'b1, A_CTRL, 32'hf0);
    soft_rst <= 1'b1;
    @(posedge clk_i);
    soft_rst <= 1'b0;
    rdchk("ctrl_soft", A_CTRL, 32'h0f);
    rdchk("mask_soft", A_MASK, 32'h0);
    check("dec_soft", 32'(dec_en), 1);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule : lfrc_ctrl_tb
